// ---- bwf_pkg.sv ----
// constants and carrier types for the backplane word framer
package bwf_pkg;

    // serial word layout
    localparam int          WORD_BITS      = 34;
    localparam int          OB_HI          = 33;
    localparam int          OB_LO          = 32;
    localparam int          CMD_MARK_BIT   = 31;
    localparam int          SUB_HI         = 30;
    localparam int          SUB_LO         = 29;
    localparam int          CMD_HI         = 28;
    localparam int          CMD_LO         = 24;
    localparam int          PAY_HI         = 23;
    localparam int          PAY_LO         = 8;
    localparam int          DLY_HI         = 11;
    localparam int          DLY_LO         = 8;
    localparam int          TRL_HI         = 7;

    // overhead bit values
    localparam logic [1:0]  OB_COMMAND     = 2'h0;
    localparam logic [1:0]  OB_FLOW_A      = 2'h1;
    localparam logic [1:0]  OB_FLOW_B      = 2'h2;
    localparam logic [1:0]  OB_ACK_HDR     = 2'h3;

    // parallel word types
    localparam logic [1:0]  TYPE_COMMAND   = 2'h0;
    localparam logic [1:0]  TYPE_DATA      = 2'h1;
    localparam logic [1:0]  TYPE_HEADER    = 2'h2;
    localparam logic [1:0]  TYPE_CRQ       = 2'h3;

    // command types and classes
    localparam logic [4:0]  CMD_ALIGN      = 5'h00;
    localparam logic [4:0]  CMD_IDLE       = 5'h07;
    localparam logic [4:0]  CMD_SET_DELAY  = 5'h08;
    localparam logic [1:0]  CLASS_LINK     = 2'h0;
    localparam logic [1:0]  CLASS_XCVR     = 2'h1;
    localparam logic [1:0]  CLASS_SWITCH   = 2'h2;
    localparam logic [1:0]  CLASS_PORT     = 2'h3;
    localparam logic [1:0]  SUB_PLAIN      = 2'h0;
    localparam logic [7:0]  CMD_TRAILER    = 8'hAA;
    localparam logic [15:0] CMD_DEF_PAY    = 16'hAAAA;

    // own idle and its check mask
    localparam logic [33:0] IDLE_FRAME     = {OB_COMMAND, 1'b1, SUB_PLAIN, CMD_IDLE,
                                              CMD_DEF_PAY, CMD_TRAILER};
    localparam logic [33:0] IDLE_MASK      = 34'h3_9F00_00FF;

    // operating modes
    localparam logic [1:0]  MODE_MUXDEMUX  = 2'h0;
    localparam logic [1:0]  MODE_DIRECT    = 2'h1;
    localparam logic [1:0]  MODE_LOOPBACK  = 2'h2;
    localparam logic [1:0]  MODE_NORMAL    = 2'h3;

    // register map
    localparam int          ADDR_W         = 4;
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_STATUS     = 4'h4;
    localparam logic [3:0]  REG_CONN       = 4'h8;
    localparam logic [3:0]  REG_ERRCNT     = 4'hC;
    localparam int          STAT_PRESENT   = 0;
    localparam int          STAT_LINK_ERR  = 1;
    localparam int          STAT_ALIGNED   = 2;
    localparam int          STAT_DLY_LO    = 4;
    localparam int          ERRCNT_W       = 16;
    localparam logic [7:0]  CTRL_RESET     = 8'hE0;

    typedef struct packed {
        logic [1:0] mode;
        logic       tx_clk_src;
        logic       rx_sel;
        logic       far_wrap;
        logic       local_wrap;
        logic       cell_sync;
        logic       bypass;
    } bwf_ctrl_s;

    typedef struct packed {
        logic [1:0]  wtype;
        logic [31:0] data;
    } bwf_word_s;

endpackage

// ---- bwf_signal_detect.sv ----
// transition-density signal detector for the idle serial input
`timescale 1ns/1ps
`default_nettype none

module bwf_signal_detect #(
    parameter int WORDS = 8
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // monitored bit and result
    input  wire logic bit_in,
    output logic      present
);

    localparam int WIN = WORDS * bwf_pkg::WORD_BITS;
    localparam int CW  = $clog2(WIN + 1);

    typedef struct packed {
        logic          prev;
        logic [CW-1:0] win_cnt;
        logic [CW-1:0] trans_cnt;
        logic          present;
    } bwf_det_s;

    bwf_det_s det_reg;
    bwf_det_s det_next;

    // one edge per word on average
    always_comb
    begin
        det_next      = det_reg;
        det_next.prev = bit_in;
        if (det_reg.win_cnt == CW'(WIN - 1))
        begin
            det_next.win_cnt   = '0;
            det_next.trans_cnt = '0;
            det_next.present   = (det_reg.trans_cnt + CW'(bit_in != det_reg.prev))
                                 >= CW'(WORDS);
        end
        else
        begin
            det_next.win_cnt = det_reg.win_cnt + CW'(1);
            if (bit_in != det_reg.prev)
            begin
                det_next.trans_cnt = det_reg.trans_cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            det_reg <= '0;
        end
        else
        begin
            det_reg <= det_next;
        end
    end

    assign present = det_reg.present;

endmodule // bwf_signal_detect

`default_nettype wire

// ---- bwf_word_framer.sv ----
// word framer with idle, wrap and input select
//
// Overview of operation
// - overhead bits, then payload, msb first.
// - no bypass: 01/10 flow, 11 ack or header.
// - bypass: type and overhead copy both ways.
// - classes by top type bits; 00000 align, 00111 idle.
// - command 01000 loads payload 3..0 as delay.
// - idle payload is connection map, bit 15 port 0.
// - serial command: 00, one, subfield, type, payload, 0xAA.
// - subfield 00 align, 01/10 flow, 11 ack or reset.
// - idles fill the line when nothing else goes.
// - valid low sends idles instead of data.
// - received idles checked against a mask.
// - local wrap loops own output to receive.
// - far-end wrap resends the received stream.
// - select picks input, other feeds detector.
// - present while edges average one per 34 bits.
// - clock select high recovered, low own multiplier.
// - type on two bits beside the payload.
`timescale 1ns/1ps
`default_nettype none

module bwf_word_framer #(
    parameter int DET_WORDS   = 8,
    parameter int LOSS_ERRORS = 4
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // avalon-mm slave
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // parallel transmit side
    input  wire bwf_pkg::bwf_word_s tx_word,
    input  wire logic              tx_word_valid,
    output logic                   tx_word_taken,
    // parallel receive side
    output bwf_pkg::bwf_word_s     rx_word,
    output logic                   rx_word_valid,
    output logic                   rx_idle_seen,
    output logic                   rx_link_error,
    // serial lines, one bit per clock
    input  wire logic              serial_in_a,
    input  wire logic              serial_in_b,
    output logic                   serial_out_a,
    output logic                   serial_out_b,
    // status
    output logic                   signal_present,
    output logic                   tx_clock_source_select,
    output logic      [3:0]        delay_or_cellclk_in
);

    localparam int CW = $clog2(bwf_pkg::WORD_BITS);
    localparam logic [CW-1:0] LAST_BIT = CW'(bwf_pkg::WORD_BITS - 1);

    typedef enum logic [1:0] {
        RX_HUNT = 2'b01,
        RX_SYNC = 2'b10
    } bwf_rx_state_e;

    typedef struct packed {
        bwf_pkg::bwf_ctrl_s ctrl;
        logic               waitreq;
        logic [31:0]        rdata;
        logic [33:0]        tx_sh;
        logic [CW-1:0]      tx_cnt;
        logic               tx_taken;
        logic               sout;
        logic [33:0]        rx_sh;
        logic [CW-1:0]      rx_cnt;
        bwf_rx_state_e      rx_st;
        logic [2:0]         err_run;
        bwf_pkg::bwf_word_s rx_word;
        logic               rx_valid;
        logic               rx_idle;
        logic               rx_err;
        logic               link_err;
        logic [bwf_pkg::ERRCNT_W-1:0] err_cnt;
        logic [15:0]        conn;
        logic [3:0]         dly;
    } bwf_state_s;

    bwf_state_s st_reg;
    bwf_state_s st_next;
    logic       present_w;
    logic       det_bit;
    logic       rx_bit;

    // low three type bits of every class left unchecked
    function automatic logic [1:0] cmd_class(input logic [4:0] cmd);
        cmd_class = cmd[4:3];
    endfunction

    function automatic logic idle_ok(input logic [33:0] w);
        idle_ok = (w & bwf_pkg::IDLE_MASK) == (bwf_pkg::IDLE_FRAME & bwf_pkg::IDLE_MASK);
    endfunction

    function automatic logic [33:0] tx_frame(input bwf_pkg::bwf_word_s w,
                                             input logic valid, input logic bypass);
        logic [1:0] ob;
        ob = w.wtype;
        if (!valid)
        begin
            tx_frame = bwf_pkg::IDLE_FRAME;
        end
        else if (w.wtype == bwf_pkg::TYPE_COMMAND)
        begin
            if (w.data[bwf_pkg::CMD_HI:bwf_pkg::CMD_LO] == bwf_pkg::CMD_IDLE)
            begin
                tx_frame = bwf_pkg::IDLE_FRAME;
            end
            else
            begin
                tx_frame = {bwf_pkg::OB_COMMAND, 1'b1, bwf_pkg::SUB_PLAIN,
                            w.data[bwf_pkg::CMD_HI:bwf_pkg::CMD_LO],
                            w.data[bwf_pkg::PAY_HI:bwf_pkg::PAY_LO],
                            bwf_pkg::CMD_TRAILER};
            end
        end
        else
        begin
            if (bypass)
            begin
                ob = w.wtype;
            end
            else
            begin
                case (w.wtype)
                    bwf_pkg::TYPE_DATA:   ob = bwf_pkg::OB_FLOW_A;
                    bwf_pkg::TYPE_HEADER: ob = bwf_pkg::OB_ACK_HDR;
                    default:              ob = bwf_pkg::OB_COMMAND;
                endcase
            end
            tx_frame = {ob, w.data};
        end
    endfunction

    function automatic logic [1:0] rx_type(input logic [1:0] ob, input logic bypass);
        if (bypass)
        begin
            rx_type = ob;
        end
        else
        begin
            case (ob)
                bwf_pkg::OB_FLOW_A,
                bwf_pkg::OB_FLOW_B:  rx_type = bwf_pkg::TYPE_DATA;
                bwf_pkg::OB_ACK_HDR: rx_type = bwf_pkg::TYPE_HEADER;
                default:             rx_type = bwf_pkg::TYPE_COMMAND;
            endcase
        end
    endfunction

    // receive and detector sources
    always_comb
    begin
        if (st_reg.ctrl.local_wrap)
        begin
            rx_bit = st_reg.sout;
        end
        else
        begin
            rx_bit = st_reg.ctrl.rx_sel ? serial_in_b : serial_in_a;
        end
        det_bit = st_reg.ctrl.rx_sel ? serial_in_a : serial_in_b;
    end

    bwf_signal_detect #(
        .WORDS   (DET_WORDS)
    ) u_detect (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .bit_in  (det_bit),
        .present (present_w)
    );

    always_comb
    begin
        logic [33:0] sh;
        logic [4:0]  cmd;
        logic        no_align;
        sh       = {st_reg.rx_sh[32:0], rx_bit};
        cmd      = sh[bwf_pkg::CMD_HI:bwf_pkg::CMD_LO];
        no_align = (st_reg.ctrl.mode == bwf_pkg::MODE_MUXDEMUX) && st_reg.ctrl.cell_sync
                   && !st_reg.ctrl.bypass;
        st_next  = st_reg;

        // one wait cycle per access
        st_next.waitreq = !((avs_read || avs_write) && st_reg.waitreq);
        if (avs_read && st_reg.waitreq)
        begin
            case (avs_address)
                bwf_pkg::REG_CTRL:   st_next.rdata = {24'h00_0000, st_reg.ctrl};
                bwf_pkg::REG_STATUS:
                begin
                    st_next.rdata = '0;
                    st_next.rdata[bwf_pkg::STAT_PRESENT]  = present_w;
                    st_next.rdata[bwf_pkg::STAT_LINK_ERR] = st_reg.link_err;
                    st_next.rdata[bwf_pkg::STAT_ALIGNED]  = st_reg.rx_st == RX_SYNC;
                    st_next.rdata[bwf_pkg::STAT_DLY_LO +: 4] = st_reg.dly;
                end
                bwf_pkg::REG_CONN:   st_next.rdata = {16'h0000, st_reg.conn};
                bwf_pkg::REG_ERRCNT: st_next.rdata = {16'h0000, st_reg.err_cnt};
                default:             st_next.rdata = '0;
            endcase
        end
        if (avs_write && !st_reg.waitreq)
        begin
            if (avs_address == bwf_pkg::REG_CTRL)
            begin
                st_next.ctrl = avs_writedata[7:0];
            end
            else if (avs_address == bwf_pkg::REG_STATUS
                     && avs_writedata[bwf_pkg::STAT_LINK_ERR])
            begin
                st_next.link_err = 1'b0;
            end
            else if (avs_address == bwf_pkg::REG_ERRCNT)
            begin
                st_next.err_cnt = '0;
            end
        end

        // new word every 34 bits
        st_next.tx_taken = 1'b0;
        if (st_reg.tx_cnt == LAST_BIT)
        begin
            st_next.tx_cnt   = '0;
            st_next.tx_sh    = tx_frame(tx_word, tx_word_valid, st_reg.ctrl.bypass);
            st_next.tx_taken = tx_word_valid;
        end
        else
        begin
            st_next.tx_cnt = st_reg.tx_cnt + CW'(1);
            st_next.tx_sh  = {st_reg.tx_sh[32:0], 1'b0};
        end
        // far-end wrap wins the output
        st_next.sout = st_reg.ctrl.far_wrap ? rx_bit : st_reg.tx_sh[33];

        // hunt for an idle, then frame
        st_next.rx_sh    = sh;
        st_next.rx_valid = 1'b0;
        st_next.rx_idle  = 1'b0;
        st_next.rx_err   = 1'b0;
        case (st_reg.rx_st)
            RX_HUNT:
            begin
                if (no_align || idle_ok(sh))
                begin
                    st_next.rx_st   = RX_SYNC;
                    st_next.rx_cnt  = '0;
                    st_next.err_run = '0;
                end
            end
            RX_SYNC:
            begin
                if (st_reg.rx_cnt != LAST_BIT)
                begin
                    st_next.rx_cnt = st_reg.rx_cnt + CW'(1);
                end
                else
                begin
                    st_next.rx_cnt = '0;
                    if (sh[bwf_pkg::OB_HI:bwf_pkg::OB_LO] == bwf_pkg::OB_COMMAND
                        && cmd == bwf_pkg::CMD_IDLE)
                    begin
                        st_next.rx_idle = 1'b1;
                        if (!idle_ok(sh))
                        begin
                            st_next.rx_err   = 1'b1;
                            st_next.link_err = 1'b1;
                            if (st_reg.err_cnt != '1)
                            begin
                                st_next.err_cnt = st_reg.err_cnt + bwf_pkg::ERRCNT_W'(1);
                            end
                            st_next.err_run = st_reg.err_run + 3'd1;
                            // bad idle run: boundary lost
                            if (st_reg.err_run + 3'd1 >= 3'(LOSS_ERRORS) && !no_align)
                            begin
                                st_next.rx_st = RX_HUNT;
                            end
                        end
                        else
                        begin
                            st_next.err_run = '0;
                            st_next.conn    = {<<{sh[bwf_pkg::PAY_HI:bwf_pkg::PAY_LO]}};
                        end
                    end
                    else if (sh[bwf_pkg::OB_HI:bwf_pkg::OB_LO] == bwf_pkg::OB_COMMAND
                             && sh[bwf_pkg::CMD_MARK_BIT] && !st_reg.ctrl.bypass
                             && (cmd_class(cmd) == bwf_pkg::CLASS_LINK
                                 || cmd_class(cmd) == bwf_pkg::CLASS_XCVR))
                    begin
                        // own commands consumed here
                        if (cmd == bwf_pkg::CMD_SET_DELAY)
                        begin
                            st_next.dly = sh[bwf_pkg::DLY_HI:bwf_pkg::DLY_LO];
                        end
                    end
                    else
                    begin
                        st_next.rx_valid      = 1'b1;
                        st_next.rx_word.wtype = rx_type(sh[bwf_pkg::OB_HI:bwf_pkg::OB_LO],
                                                        st_reg.ctrl.bypass);
                        st_next.rx_word.data  = sh[31:0];
                    end
                end
            end
            default:
            begin
                st_next.rx_st = RX_HUNT;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg         <= '0;
            st_reg.ctrl    <= bwf_pkg::CTRL_RESET;
            st_reg.waitreq <= 1'b1;
            st_reg.rx_st   <= RX_HUNT;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata           = st_reg.rdata;
    assign avs_waitrequest        = st_reg.waitreq;
    assign tx_word_taken          = st_reg.tx_taken;
    assign rx_word                = st_reg.rx_word;
    assign rx_word_valid          = st_reg.rx_valid;
    assign rx_idle_seen           = st_reg.rx_idle;
    assign rx_link_error          = st_reg.rx_err;
    assign serial_out_a           = st_reg.sout;
    assign serial_out_b           = st_reg.sout;
    assign signal_present         = present_w;
    assign tx_clock_source_select = st_reg.ctrl.tx_clk_src;
    assign delay_or_cellclk_in    = st_reg.dly;

endmodule // bwf_word_framer

`default_nettype wire

// ---- bwf_word_framer_sva.sv ----
// port checker for the backplane word framer
`timescale 1ns/1ps
`default_nettype none

module bwf_word_framer_chk (
    // clock and reset
    input wire logic               clk_sys,
    input wire logic               rst_n,
    // register bus
    input wire logic [3:0]         avs_address,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic [31:0]        avs_writedata,
    input wire logic               avs_waitrequest,
    // word sides and lines
    input wire logic               tx_word_valid,
    input wire logic               tx_word_taken,
    input wire bwf_pkg::bwf_word_s rx_word,
    input wire logic               rx_word_valid,
    input wire logic               rx_link_error,
    input wire logic               serial_out_a,
    input wire logic               serial_out_b,
    input wire logic               tx_clock_source_select
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire ctrl_wr = avs_write && !avs_waitrequest && (avs_address == bwf_pkg::REG_CTRL);

    property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait not one cycle");
    property p_src_hold; !ctrl_wr |=> $stable(tx_clock_source_select); endproperty
    a_src_hold: assert property (p_src_hold) else $error("clock select moved");
    property p_src_load; ctrl_wr |=> tx_clock_source_select == $past(avs_writedata[5]); endproperty
    a_src_load: assert property (p_src_load) else $error("clock select not loaded");
    property p_valid_low; !tx_word_valid |=> !tx_word_taken; endproperty
    a_valid_low: assert property (p_valid_low) else $error("word taken while invalid");
    property p_outs_equal; serial_out_a == serial_out_b; endproperty
    a_outs_equal: assert property (p_outs_equal) else $error("serial outputs differ");
    property p_err_kept; rx_link_error |-> !rx_word_valid; endproperty
    a_err_kept: assert property (p_err_kept) else $error("bad idle delivered");
    property p_rx_gap; rx_word_valid |=> !rx_word_valid [*8]; endproperty
    a_rx_gap: assert property (p_rx_gap) else $error("rx words too close");
    property p_tx_gap; tx_word_taken |=> !tx_word_taken [*8]; endproperty
    a_tx_gap: assert property (p_tx_gap) else $error("tx loads too close");
    property p_rx_hold; !rx_word_valid |-> $stable(rx_word); endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx word changed");
endmodule // bwf_word_framer_chk

bind bwf_word_framer bwf_word_framer_chk u_bwf_word_framer_chk (
    .clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_waitrequest, .tx_word_valid, .tx_word_taken, .rx_word, .rx_word_valid,
    .rx_link_error, .serial_out_a, .serial_out_b, .tx_clock_source_select
);
`default_nettype wire

// ---- bwf_far_end.sv ----
// far-end model: serial word source plus a spare line for the detector
`timescale 1ns/1ps
`default_nettype none

module bwf_far_end (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // word to repeat and spare control
    input  wire logic [33:0] word_in,
    input  wire logic        quiet,
    // lines and boundary mark
    output logic             line_out,
    output logic             spare_out,
    output logic             word_start
);
    logic [33:0] shift_reg;
    logic [5:0]  cnt_reg;
    logic [1:0]  tog_reg;
    assign line_out   = shift_reg[33];
    assign word_start = (cnt_reg == 6'h21);
    // a dead spare stands low, a live one toggles every two bits
    assign spare_out  = quiet ? 1'b0 : tog_reg[1];
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_reg <= 34'h0_0000_0000;
            cnt_reg   <= 6'h00;
            tog_reg   <= 2'h0;
        end
        else
        begin
            // idles carry the map via word_in
            cnt_reg   <= word_start ? 6'h00 : cnt_reg + 6'h01;
            shift_reg <= word_start ? word_in : {shift_reg[32:0], 1'b0};
            tog_reg   <= tog_reg + 2'h1;
        end
    end
endmodule // bwf_far_end
`default_nettype wire

// ---- bwf_word_framer_bench.sv ----
// self-checking bench for the backplane word framer
`timescale 1ns/1ps
`default_nettype none

module bwf_word_framer_bench;
    localparam logic [33:0] Z34      = 34'h0_0000_0000;
    localparam logic [33:0] ONE      = 34'h0_0000_0001;
    localparam logic [32:0] Z33      = 33'h0_0000_0000;
    localparam logic [33:0] FAR_IDLE = 34'h0_87C0_01AA;
    localparam logic [33:0] FAR_DATA = 34'h1_2468_ACE0;
    localparam logic [7:0]  CC [5]   = '{8'hE0, 8'hE0, 8'hE0, 8'hE1, 8'hE1};
    localparam logic [33:0] TW [5]   = '{34'h1_A5A5_0F0F, 34'h2_0123_4567, 34'h0_1C12_3455,
                                         34'h2_89AB_CDEF, 34'h3_7654_3210};
    localparam logic [33:0] EX [5]   = '{34'h1_A5A5_0F0F, 34'h3_0123_4567, 34'h0_9C12_34AA,
                                         34'h2_89AB_CDEF, 34'h3_7654_3210};
    localparam logic [33:0] RW [2]   = '{34'h1_DEAD_BEEF, 34'h3_1357_9BDF};
    localparam logic [33:0] RX [2]   = '{34'h1_DEAD_BEEF, 34'h2_1357_9BDF};
    logic               clk_sys = 1'b0;
    logic               rst_n = 1'b0;
    logic [3:0]         avs_address = 4'h0;
    logic               avs_read = 1'b0, avs_write = 1'b0, tx_word_valid = 1'b0, quiet = 1'b0;
    logic [31:0]        avs_writedata = 32'h0000_0000;
    logic [31:0]        avs_readdata, rd;
    bwf_pkg::bwf_word_s tx_word = Z34;
    bwf_pkg::bwf_word_s rx_word;
    logic               avs_waitrequest, tx_word_taken, rx_word_valid, rx_idle_seen;
    logic               rx_link_error, serial_in_a, serial_in_b, serial_out_a, serial_out_b;
    logic               signal_present, tx_clock_source_select, word_start, ok;
    logic [3:0]         delay_or_cellclk_in;
    logic [33:0]        far_word = FAR_DATA;
    logic [33:0]        out_win = Z34;
    int                 n_errors = 0, checks_done = 0, cyc = 0;

    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) out_win <= {out_win[32:0], serial_out_a};
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    bwf_word_framer #(.DET_WORDS(2), .LOSS_ERRORS(4)) u_bwf_word_framer (
        .clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .tx_word, .tx_word_valid, .tx_word_taken,
        .rx_word, .rx_word_valid, .rx_idle_seen, .rx_link_error, .serial_in_a,
        .serial_in_b, .serial_out_a, .serial_out_b, .signal_present,
        .tx_clock_source_select, .delay_or_cellclk_in);
    bwf_far_end u_bwf_far_end (.clk_sys, .rst_n, .word_in(far_word), .quiet,
        .line_out(serial_in_a), .spare_out(serial_in_b), .word_start);

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // held until waitrequest low; only the timeout ends a wait
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do
        begin
            @(posedge clk_sys);
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk_sys);
    endtask

    // bounded wait; 5 matches an output word
    task automatic wait_for(input int sel, input int lim, input logic [33:0] exp);
        ok = 1'b0;
        for (int i = 0; i < lim && !ok; i++)
        begin
            @(posedge clk_sys);
            case (sel)
                0: ok = rx_idle_seen === 1'b1;
                1: ok = rx_word_valid === 1'b1;
                2: ok = rx_link_error === 1'b1;
                3: ok = tx_word_taken === 1'b1;
                4: ok = word_start === 1'b1;
                default: ok = out_win === exp;
            endcase
        end
        chk({Z33, ok}, ONE);
    endtask

    task automatic send(input logic [33:0] w);
        tx_word       <= w;
        tx_word_valid <= 1'b1;
        wait_for(3, 80, Z34);
        tx_word_valid <= 1'b0;
        @(posedge clk_sys);
    endtask

    // one word between idles
    task automatic inject(input logic [33:0] w);
        wait_for(4, 40, Z34);
        far_word <= w;
        @(posedge clk_sys);
        wait_for(4, 40, Z34);
        far_word <= FAR_IDLE;
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk({Z33, avs_waitrequest}, ONE);
        chk({Z33, tx_clock_source_select}, ONE);
        bus(1'b0, bwf_pkg::REG_CTRL, 32'h0000_0000);
        chk({2'h0, rd}, 34'h0_0000_00E0);
        bus(1'b0, 4'h2, 32'h0000_0000);
        chk({2'h0, rd}, Z34);
        $display("test reset done");
        bus(1'b1, bwf_pkg::REG_CTRL, 32'h0000_0085);
        chk({Z33, tx_clock_source_select}, Z34);
        wait_for(0, 300, Z34);
        $display("test local wrap done");
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, bwf_pkg::REG_CTRL, {24'h00_0000, CC[i]});
            send(TW[i]);
            wait_for(5, 120, EX[i]);
        end
        wait_for(5, 80, 34'h0_87AA_AAAA);
        $display("test transmit framing done");
        bus(1'b1, bwf_pkg::REG_CTRL, 32'h0000_00E8);
        wait_for(5, 150, FAR_DATA);
        far_word <= FAR_IDLE;
        // reset again: the far stream is a bit off the wrapped boundary
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk({Z33, avs_waitrequest}, ONE);
        $display("test far wrap done");
        wait_for(0, 700, Z34);
        repeat (100) @(posedge clk_sys);
        bus(1'b1, bwf_pkg::REG_ERRCNT, 32'h0000_0000);
        bus(1'b0, bwf_pkg::REG_CONN, 32'h0000_0000);
        chk({2'h0, rd}, 34'h0_0000_8003);
        inject(34'h0_8800_A5AA);
        repeat (80) @(posedge clk_sys);
        chk({30'h0000_0000, delay_or_cellclk_in}, 34'h0_0000_0005);
        for (int i = 0; i < 2; i++)
        begin
            inject(RW[i]);
            wait_for(1, 80, Z34);
            chk(rx_word, RX[i]);
        end
        inject(34'h0_87C0_01AB);
        wait_for(2, 80, Z34);
        bus(1'b0, bwf_pkg::REG_ERRCNT, 32'h0000_0000);
        chk({2'h0, rd}, ONE);
        bus(1'b0, bwf_pkg::REG_STATUS, 32'h0000_0000);
        chk({2'h0, rd}, 34'h0_0000_0057);
        $display("test receive done");
        chk({Z33, signal_present}, ONE);
        quiet <= 1'b1;
        repeat (250) @(posedge clk_sys);
        chk({Z33, signal_present}, Z34);
        $display("test signal detect done");
        print_verdict();
    end
endmodule // bwf_word_framer_bench
`default_nettype wire
